//--- pwcg_map.vh
// Register map, field positions, reset values and timing counts for the
// power, wake and clock gating block. Assumes a 200 MHz device clock.
`ifndef PWCG_MAP_VH
`define PWCG_MAP_VH

// ************************************************************
// Register offsets
// ************************************************************
`define PWCG_OFF_MODE_STATUS 8'h32
`define PWCG_OFF_EVENT_EN 8'h34
`define PWCG_OFF_SLEEP_DELAY 8'h36
`define PWCG_OFF_CLK_GATE 8'h38

// ************************************************************
// Field positions and reset values
// ************************************************************
`define PWCG_BIT_WAKE_FRAME 5
`define PWCG_BIT_MAGIC 4
`define PWCG_BIT_LINK_UP 3
`define PWCG_BIT_ENERGY 2
`define PWCG_BIT_POLARITY 4
`define PWCG_BIT_SW_AUTO 3
`define PWCG_BIT_CPU_AUTO 2
`define PWCG_MODE_NORMAL 2'h0
`define PWCG_MODE_ENERGY 2'h1
`define PWCG_MODE_SOFT_PD 2'h2
`define PWCG_MODE_CLEAR_KEY 4'h1
`define PWCG_RST_SLEEP_DELAY 8'h8E

// ************************************************************
// Timing: clock in MHz, times as printed, cycle counts derived
// ************************************************************
`define PWCG_CLK_MHZ 200
`define PWCG_UNIT_MS 20
`define PWCG_UNIT_CYC (`PWCG_UNIT_MS * 1000 * `PWCG_CLK_MHZ)
`define PWCG_WAIT0_MS 5300
`define PWCG_WAIT1_MS 1600
`define PWCG_WAIT2_MS 1
`define PWCG_WAIT3_NS 3200
`define PWCG_WAIT0_CYC (`PWCG_WAIT0_MS * 1000 * `PWCG_CLK_MHZ)
`define PWCG_WAIT1_CYC (`PWCG_WAIT1_MS * 1000 * `PWCG_CLK_MHZ)
`define PWCG_WAIT2_CYC (`PWCG_WAIT2_MS * 1000 * `PWCG_CLK_MHZ)
`define PWCG_WAIT3_CYC (`PWCG_WAIT3_NS * `PWCG_CLK_MHZ / 1000)

`endif

//--- pwcg_idle_timer.v
// Idle timer: counts cycles of continuous inactivity and flags expiry.
// Assumes activity and limit are synchronous to mclk.
`timescale 1ns/1ps

module pwcg_idle_timer (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Control
  input wire busy,
  input wire [31:0] limit,
  // Result
  output reg expired
);

  reg [31:0] count;

  // Restart on activity; saturate once the limit is reached
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 32'h0;
      expired <= 1'b0;
    end else if (busy) begin
      count <= 32'h0;
      expired <= 1'b0;
    end else if (count < limit) begin
      count <= count + 32'h1;
    end else begin
      expired <= 1'b1;
    end
  end

endmodule // pwcg_idle_timer

//--- pwcg_top.v
// Power management, wake events and clock tree gating.
// Assumes a 16-bit synchronous register port and event pulses on mclk.
`timescale 1ns/1ps
`include "pwcg_map.vh"

module pwcg_top #(
  parameter UNIT_CYC = `PWCG_UNIT_CYC,
  parameter WAIT0_CYC = `PWCG_WAIT0_CYC,
  parameter WAIT1_CYC = `PWCG_WAIT1_CYC,
  parameter WAIT2_CYC = `PWCG_WAIT2_CYC
) (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  // Wake events from ports and host queue unit
  input wire wake_frame_det,
  input wire magic_packet_det,
  input wire link_up_det,
  input wire energy_det,
  // Activity monitors
  input wire mii_busy,
  input wire host_busy,
  // Outputs
  output reg power_event_pin,
  output reg [1:0] power_mode,
  output reg low_power_state,
  output reg switch_clk_en,
  output reg cpu_clk_en
);

  // ************************************************************
  // Registers
  // ************************************************************
  reg [5:2] wake_status;
  reg [4:0] event_enable;
  reg [7:0] sleep_delay;
  reg [4:0] clk_gate_ctrl;

  wire wr_mode = reg_wr && (reg_addr == `PWCG_OFF_MODE_STATUS);
  wire wr_en = reg_wr && (reg_addr == `PWCG_OFF_EVENT_EN);
  wire wr_sleep = reg_wr && (reg_addr == `PWCG_OFF_SLEEP_DELAY);
  wire wr_gate = reg_wr && (reg_addr == `PWCG_OFF_CLK_GATE);

  // Clear key wins over the mode write; the same write also clears status bit 2 by W1C
  wire mode_clear = wr_mode && (reg_wdata[5:2] == `PWCG_MODE_CLEAR_KEY);

  // ************************************************************
  // Sticky wake status; a new event wins over a same-cycle clear
  // ************************************************************
  wire [5:2] events = {wake_frame_det, magic_packet_det, link_up_det, energy_det};
  wire [5:2] w1c = wr_mode ? reg_wdata[5:2] : 4'h0;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wake_status <= 4'h0;
    end else begin
      wake_status <= (wake_status & ~w1c) | events;
    end
  end

  // Mode field and other writable controls
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      power_mode <= `PWCG_MODE_NORMAL;
      event_enable <= 5'h0;
      sleep_delay <= `PWCG_RST_SLEEP_DELAY;
      clk_gate_ctrl <= 5'h0;
    end else begin
      if (mode_clear) begin
        power_mode <= `PWCG_MODE_NORMAL;
      end else if (wr_mode) begin
        power_mode <= reg_wdata[1:0];
      end
      if (wr_en) begin
        event_enable <= reg_wdata[4:0];
      end
      if (wr_sleep) begin
        sleep_delay <= reg_wdata[7:0];
      end
      if (wr_gate) begin
        clk_gate_ctrl <= reg_wdata[4:0];
      end
    end
  end

  // ************************************************************
  // Read path, registered; unmapped offsets read zero
  // ************************************************************
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `PWCG_OFF_MODE_STATUS: reg_rdata <= {10'h0, wake_status, power_mode};
        `PWCG_OFF_EVENT_EN: reg_rdata <= {11'h0, event_enable};
        `PWCG_OFF_SLEEP_DELAY: reg_rdata <= {8'h0, sleep_delay};
        `PWCG_OFF_CLK_GATE: reg_rdata <= {11'h0, clk_gate_ctrl};
        default: reg_rdata <= 16'h0;
      endcase
    end
  end

  // ************************************************************
  // Power event pin
  // ************************************************************
  // Enable bits 3..0 line up with status bits 5..2
  wire pme_active = |(wake_status & event_enable[3:0]);

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      power_event_pin <= 1'b1; // Inactive for default active-low polarity
    end else begin
      power_event_pin <= pme_active ~^ event_enable[`PWCG_BIT_POLARITY];
    end
  end

  // ************************************************************
  // Go-sleep timer for energy detect mode
  // ************************************************************
  // Unit divider gives one pulse per 20 ms of continuous no-energy
  reg [31:0] unit_cnt;
  reg [7:0] unit_total;
  wire unit_tick = (unit_cnt == UNIT_CYC - 1);
  wire in_energy_mode = (power_mode == `PWCG_MODE_ENERGY);

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      unit_cnt <= 32'h0;
      unit_total <= 8'h0;
      low_power_state <= 1'b0;
    end else if (!in_energy_mode || energy_det) begin
      unit_cnt <= 32'h0;
      unit_total <= 8'h0;
      low_power_state <= 1'b0;
    end else if (unit_total >= sleep_delay) begin
      low_power_state <= 1'b1;
    end else if (unit_tick) begin
      unit_cnt <= 32'h0;
      unit_total <= unit_total + 8'h1;
    end else begin
      unit_cnt <= unit_cnt + 32'h1;
    end
  end

  // ************************************************************
  // Clock tree gating
  // ************************************************************
  // Wait period lookup; used for both gates
  function [31:0] wait_cycles;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: wait_cycles = WAIT0_CYC;
        2'h1: wait_cycles = WAIT1_CYC;
        2'h2: wait_cycles = WAIT2_CYC;
        default: wait_cycles = `PWCG_WAIT3_CYC;
      endcase
    end
  endfunction

  wire [31:0] wait_limit = wait_cycles(clk_gate_ctrl[1:0]);
  wire sw_idle;
  wire cpu_idle;

  pwcg_idle_timer u_sw_timer (
    .mclk(mclk),
    .arst_n(arst_n),
    .busy(mii_busy),
    .limit(wait_limit),
    .expired(sw_idle)
  );

  pwcg_idle_timer u_cpu_timer (
    .mclk(mclk),
    .arst_n(arst_n),
    .busy(mii_busy | host_busy),
    .limit(wait_limit),
    .expired(cpu_idle)
  );

  // Activity restarts a clock on the same edge that clears the timer
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      switch_clk_en <= 1'b1;
      cpu_clk_en <= 1'b1;
    end else begin
      switch_clk_en <= !(clk_gate_ctrl[`PWCG_BIT_SW_AUTO] && sw_idle
        && !mii_busy);
      cpu_clk_en <= !(clk_gate_ctrl[`PWCG_BIT_CPU_AUTO] && cpu_idle
        && !mii_busy && !host_busy);
    end
  end

endmodule // pwcg_top

//--- pwcg_host_mon.sv
// Host side model that watches the power event pin.
// Assumes the pin is driven from mclk and its polarity is known.
`timescale 1ns/1ps

module pwcg_host_mon (
  // Clock
  input wire mclk,
  // Pin and the level the host treats as active
  input wire power_event_pin,
  input wire active_high,
  // Wake request as the host sees it
  output logic wake_req
);
  // Sampled like a level interrupt, so it lags the pin by one cycle
  always @(posedge mclk) begin
    wake_req <= (power_event_pin == active_high);
  end
endmodule // pwcg_host_mon

//--- pwcg_props.sv
// Port checker for the power, wake and clock gating block.
// Assumes it is bound onto pwcg_top and sees only its ports.
`timescale 1ns/1ps

module pwcg_props (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  // Events, activity and outputs
  input wire wake_frame_det,
  input wire magic_packet_det,
  input wire link_up_det,
  input wire energy_det,
  input wire mii_busy,
  input wire host_busy,
  input wire power_event_pin,
  input wire [1:0] power_mode,
  input wire low_power_state,
  input wire switch_clk_en,
  input wire cpu_clk_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Status read with no competing write
  wire st_rd = reg_rd && !reg_wr && reg_addr == 8'h32;
  // Status bits must be visible on a read right after the event
  chk_wf_status: assert property (wake_frame_det ##1 st_rd |=> reg_rdata[5])
    else $error("wake frame status not set");
  chk_mp_status: assert property (magic_packet_det ##1 st_rd |=> reg_rdata[4])
    else $error("magic packet status not set");
  chk_lu_status: assert property (link_up_det ##1 st_rd |=> reg_rdata[3])
    else $error("link up status not set");
  chk_en_status: assert property (energy_det ##1 st_rd |=> reg_rdata[2])
    else $error("energy status not set");
  // Mode writes and the clearing key
  chk_mode_set: assert property (reg_wr && reg_addr == 8'h32 && reg_wdata[5:0] == 6'h01
    |=> power_mode == 2'h1)
    else $error("mode write not taken");
  chk_mode_key: assert property (reg_wr && reg_addr == 8'h32 && reg_wdata[5:2] == 4'h1
    |=> power_mode == 2'h0)
    else $error("mode not cleared by key");
  // A clock may only stop after idle cycles, and restarts at once
  chk_sw_stop: assert property ($fell(switch_clk_en)
    |-> !$past(mii_busy) && !$past(mii_busy, 2))
    else $error("switch clock stopped while busy");
  chk_sw_wake: assert property (!switch_clk_en && mii_busy |=> switch_clk_en)
    else $error("switch clock not restarted");
  chk_cpu_stop: assert property ($fell(cpu_clk_en)
    |-> !$past(host_busy) && !$past(mii_busy))
    else $error("cpu clock stopped while busy");
  chk_cpu_wake: assert property (!cpu_clk_en && (mii_busy || host_busy) |=> cpu_clk_en)
    else $error("cpu clock not restarted");
endmodule // pwcg_props

bind pwcg_top pwcg_props u_props (.mclk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .wake_frame_det, .magic_packet_det, .link_up_det, .energy_det, .mii_busy,
  .host_busy, .power_event_pin, .power_mode, .low_power_state, .switch_clk_en, .cpu_clk_en);

//--- tb_top.sv
// Self-checking bench for pwcg_top with a host pin monitor.
// Assumes shortened count parameters; tasks are entered at a falling edge.
`timescale 1ns/1ps

module tb_top;
  logic mclk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, mii_busy = 0, host_busy = 0, pol = 0;
  logic [7:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata;
  logic [3:0] ev = 0;
  logic power_event_pin, low_power_state, switch_clk_en, cpu_clk_en, wake_req;
  logic [1:0] power_mode;
  int fails = 0, checks = 0, cyc = 0, st = 0, en = 0, i, j, d;
  int lim[4] = '{20, 15, 10, 640};
  // Clock and design under test
  always #2.5 mclk = ~mclk;
  pwcg_top #(.UNIT_CYC(10), .WAIT0_CYC(20), .WAIT1_CYC(15), .WAIT2_CYC(10)) uut (
    .mclk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .wake_frame_det(ev[3]), .magic_packet_det(ev[2]), .link_up_det(ev[1]),
    .energy_det(ev[0]), .mii_busy, .host_busy, .power_event_pin, .power_mode,
    .low_power_state, .switch_clk_en, .cpu_clk_en);
  pwcg_host_mon u_mon (.mclk, .power_event_pin, .active_high(pol), .wake_req);
  // Hang guard, well above the thousand or so cycles the tests need
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  // Compare, count and report
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Register cycles; an idle cycle after each avoids double drives
  task automatic wr(logic [7:0] a, logic [15:0] v);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge mclk);
    reg_wr = 0;
    @(negedge mclk);
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] e);
    reg_rd = 1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 0;
    chk("rdata", e, reg_rdata);
    @(negedge mclk);
  endtask
  task automatic results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(67));
    repeat (20) @(negedge mclk);
    arst_n = 1;
    rd(8'h32, 0);
    rd(8'h34, 0);
    rd(8'h36, 16'h008E);
    rd(8'h38, 0);
    rd(8'h3A, 0);
    // Each event with its enable on, then with all enables off
    for (i = 0; i < 8; i++) begin
      j = i % 4;
      pol = $urandom % 2;
      en = (i < 4) ? (1 << j) : 0;
      wr(8'h34, 16'(en + 16 * pol));
      ev[j] = 1;
      @(negedge mclk);
      ev[j] = 0;
      st = 1 << (j + 2);
      rd(8'h32, 16'(st));
      repeat (2) @(negedge mclk);
      chk("pin", (en != 0) == pol, power_event_pin);
      chk("wake", en != 0, wake_req);
      wr(8'h32, 16'h0000);
      rd(8'h32, 16'(st));
      wr(8'h32, 16'(st));
      chk("pin", pol == 0, power_event_pin);
      rd(8'h32, 0);
    end
    // Mode field and clearing key
    wr(8'h32, 16'h0002);
    chk("mode", 2, power_mode);
    wr(8'h32, 16'h0004);
    chk("mode", 0, power_mode);
    // Go-sleep after a random number of units without energy
    d = 1 + $urandom % 4;
    wr(8'h36, 16'(d));
    rd(8'h36, 16'(d));
    wr(8'h32, 16'h0001);
    repeat (d * 10 - 3) @(negedge mclk);
    chk("sleep", 0, low_power_state);
    repeat (8) @(negedge mclk);
    chk("sleep", 1, low_power_state);
    wr(8'h32, 16'h0004);
    // Clock gating at every wait setting; busy held across the write
    for (i = 0; i < 4; i++) begin
      host_busy = 1;
      mii_busy = 1;
      wr(8'h38, 16'(12 + i));
      host_busy = 0;
      mii_busy = 0;
      repeat (lim[i] - 3) @(negedge mclk);
      chk("sw_on", 1, switch_clk_en);
      repeat (8) @(negedge mclk);
      chk("sw_off", 0, switch_clk_en);
      chk("cpu_off", 0, cpu_clk_en);
      host_busy = 1;
      @(negedge mclk);
      chk("cpu_on", 1, cpu_clk_en);
      chk("sw_held", 0, switch_clk_en);
      mii_busy = 1;
      @(negedge mclk);
      chk("sw_on", 1, switch_clk_en);
    end
    wr(8'h38, 16'h0003);
    host_busy = 0;
    mii_busy = 0;
    rd(8'h38, 16'h0003);
    repeat (30) @(negedge mclk);
    chk("sw_run", 1, switch_clk_en);
    chk("cpu_run", 1, cpu_clk_en);
    results();
  end
endmodule // tb_top
